// File: logic/cmb_ahb_slave.sv
module cmb_ahb_slave import cmb_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register side
    cmb_reg_if.slave rbus
);
    logic pend_q;
    logic wr_q;
    logic [31:0] addr_q;
    logic rdy_q;
    logic [31:0] rdata_q;
    wire take = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;

    // Every transfer gets one wait state so read data leaves from a flop
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 32'h0000_0000;
            rdy_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (take) begin
            pend_q <= 1'b1;
            wr_q <= hwrite;
            addr_q <= haddr;
            rdy_q <= 1'b0;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            rdy_q <= 1'b1;
            rdata_q <= wr_q ? 32'h0000_0000 : rbus.rdata;
        end
    end

    assign rbus.wr = pend_q & wr_q;
    assign rbus.addr = addr_q;
    assign rbus.wdata = hwdata;
    assign hreadyout = rdy_q;
    assign hrdata = rdata_q;
    assign hresp = HRESP_OKAY;
endmodule // cmb_ahb_slave

// File: logic/cmb_bist_group.sv
module cmb_bist_group import cmb_pkg::*; #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control side
    cmb_bist_if.eng ctl,
    // Test port shared by both ways of the group
    output logic [AW-1:0] ram_addr,
    output logic [DW-1:0] ram_wdata,
    output logic ram_we,
    output logic ram_re,
    input wire logic [DW-1:0] ram_q0,
    input wire logic [DW-1:0] ram_q1
);
    localparam logic [DW-1:0] PAT = DW'({DW{2'b01}});
    localparam logic [AW-1:0] LAST = {AW{1'b1}};

    cmb_bist_state_type state_q;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] wdata_q;
    logic [DW-1:0] exp_q;
    logic we_q;
    logic re_q;
    logic chk_q;
    logic busy_q;
    logic done_q;
    logic [1:0] fail_q;
    wire at_last = addr_q == LAST;

    // Write pattern, read it back, then the same with its complement
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= BST_IDLE;
            addr_q <= '0;
            wdata_q <= '0;
            exp_q <= '0;
            we_q <= 1'b0;
            re_q <= 1'b0;
            chk_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 2'b00;
        end else begin
            done_q <= 1'b0;
            chk_q <= re_q;
            exp_q <= wdata_q;
            case (state_q)
                BST_IDLE: begin
                    if (ctl.start) begin
                        state_q <= BST_WR0;
                        addr_q <= '0;
                        wdata_q <= PAT;
                        we_q <= 1'b1;
                        busy_q <= 1'b1;
                        fail_q <= 2'b00;
                    end
                end
                BST_WR0: begin
                    addr_q <= addr_q + 1'b1;
                    if (at_last) begin
                        state_q <= BST_RD0;
                        we_q <= 1'b0;
                        re_q <= 1'b1;
                    end
                end
                BST_RD0: begin
                    addr_q <= addr_q + 1'b1;
                    if (at_last) begin
                        state_q <= BST_WR1;
                        wdata_q <= ~PAT;
                        we_q <= 1'b1;
                        re_q <= 1'b0;
                    end
                end
                BST_WR1: begin
                    addr_q <= addr_q + 1'b1;
                    if (at_last) begin
                        state_q <= BST_RD1;
                        we_q <= 1'b0;
                        re_q <= 1'b1;
                    end
                end
                BST_RD1: begin
                    addr_q <= addr_q + 1'b1;
                    if (at_last) begin
                        state_q <= BST_FIN;
                        re_q <= 1'b0;
                    end
                end
                BST_FIN: begin
                    state_q <= BST_IDLE;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                default: begin
                    state_q <= BST_IDLE;
                end
            endcase
            if (chk_q) begin
                fail_q <= fail_q | {ram_q1 != exp_q, ram_q0 != exp_q};
            end
        end
    end

    assign ram_addr = addr_q;
    assign ram_wdata = wdata_q;
    assign ram_we = we_q;
    assign ram_re = re_q;
    assign ctl.busy = busy_q;
    assign ctl.done = done_q;
    assign ctl.fail = fail_q;
endmodule // cmb_bist_group

// File: logic/cmb_cache_maint.sv
module cmb_cache_maint import cmb_pkg::*; #(
    parameter int BIST_AW = 8,
    parameter int BIST_DW = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Maintenance request to the cache controller
    output logic mnt_req,
    output cmb_op_type mnt_op,
    output logic mnt_instr_side,
    output logic mnt_data_side,
    output logic mnt_way,
    output logic [TARGET_LINE_W-1:0] mnt_line_addr,
    input wire logic mnt_done,
    // Self-test ports, index 0 instr arrays, 1 data arrays, 2 instr tags, 3 data tags
    output logic [NUM_GROUPS-1:0][BIST_AW-1:0] bist_addr,
    output logic [NUM_GROUPS-1:0][BIST_DW-1:0] bist_wdata,
    output logic [NUM_GROUPS-1:0] bist_we,
    output logic [NUM_GROUPS-1:0] bist_re,
    input wire logic [NUM_GROUPS-1:0][BIST_DW-1:0] bist_q_way0,
    input wire logic [NUM_GROUPS-1:0][BIST_DW-1:0] bist_q_way1,
    // Self-test state
    output logic bist_running
);
    cmb_reg_if rbus();

    cmb_ahb_slave u_ahb (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rbus(rbus.slave)
    );

    // Registers
    logic [31:0] target_q;
    logic [CMD_W-1:0] cmd_q;
    logic go_q;
    logic [NUM_GROUPS-1:0] grp_sel_q;
    logic finish_q;
    logic [FAIL_W-1:0] fail_q;
    logic running_q;
    logic [NUM_GROUPS-1:0] grp_start_q;
    logic [NUM_GROUPS-1:0] grp_act_q;

    // Maintenance sequencer state
    cmb_mnt_state_type mnt_state_q;
    logic [CMD_W-1:0] cur_mask_q;
    logic req_q;
    cmb_op_type op_q;
    logic iside_q;
    logic dside_q;
    logic way_q;
    logic [TARGET_LINE_W-1:0] line_q;

    // Address decode
    wire sel_cmd = rbus.addr == CMD_ADDR;
    wire sel_target = rbus.addr == TARGET_ADDR;
    wire sel_tctrl = rbus.addr == STEST_CTRL_ADDR;
    wire sel_tres = rbus.addr == STEST_RES_ADDR;
    wire wr_target = rbus.wr & sel_target;
    wire wr_tctrl = rbus.wr & sel_tctrl;

    // Command decode
    wire [CMD_W-1:0] pending = cmd_q & CMD_OP_MASK;
    wire cmd_busy = |pending;
    wire wr_cmd = rbus.wr & sel_cmd & ~cmd_busy;
    wire [CMD_W-1:0] pick_mask = pending & (8'h00 - pending);
    wire want_i = cmd_q[CMD_ISIDE_BIT];
    wire want_d = cmd_q[CMD_DSIDE_BIT];
    wire pick_line = pick_mask[CMD_FLUSH_LINE_BIT] | pick_mask[CMD_UNLOCK_LINE_BIT];
    wire pick_drain = pick_mask[CMD_DRAIN_BIT];
    wire bad_both = pick_line & want_i & want_d;
    wire bad_drain = pick_drain & (want_i | ~want_d);
    wire bad_none = ~want_i & ~want_d;
    wire pick_invalid = bad_both | bad_drain | bad_none;

    wire cmb_op_type pick_op =
        pick_mask[CMD_FLUSH_LINE_BIT] ? OP_FLUSH_LINE :
        pick_mask[CMD_FLUSH_ALL_BIT] ? OP_FLUSH_ALL :
        pick_mask[CMD_UNLOCK_LINE_BIT] ? OP_UNLOCK_LINE :
        pick_mask[CMD_UNLOCK_ALL_BIT] ? OP_UNLOCK_ALL :
        pick_drain ? OP_DRAIN : OP_NONE;

    // Maintenance sequencer: one command bit at a time, lowest bit first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_q <= CMD_RST;
            mnt_state_q <= MNT_IDLE;
            cur_mask_q <= CMD_RST;
            req_q <= 1'b0;
            op_q <= OP_NONE;
            iside_q <= 1'b0;
            dside_q <= 1'b0;
            way_q <= 1'b0;
            line_q <= '0;
        end else begin
            case (mnt_state_q)
                MNT_IDLE: begin
                    if (wr_cmd) begin
                        cmd_q <= rbus.wdata[CMD_W-1:0] & CMD_WR_MASK;
                    end else if (cmd_busy && pick_invalid) begin
                        cmd_q <= cmd_q & ~pick_mask;
                    end else if (cmd_busy) begin
                        req_q <= 1'b1;
                        op_q <= pick_op;
                        cur_mask_q <= pick_mask;
                        iside_q <= want_i;
                        dside_q <= want_d;
                        way_q <= target_q[TARGET_WAY_BIT];
                        line_q <= target_q[TARGET_LINE_W-1:0];
                        mnt_state_q <= MNT_WAIT;
                    end
                end
                MNT_WAIT: begin
                    if (mnt_done) begin
                        req_q <= 1'b0;
                        op_q <= OP_NONE;
                        cmd_q <= cmd_q & ~cur_mask_q;
                        mnt_state_q <= MNT_IDLE;
                    end
                end
                default: begin
                    mnt_state_q <= MNT_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // Line target register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            target_q <= TARGET_RST;
        end else if (wr_target) begin
            target_q <= rbus.wdata;
        end
    end

    // Self-test groups
    logic [NUM_GROUPS-1:0] grp_busy;
    logic [NUM_GROUPS-1:0] grp_done;
    logic [FAIL_W-1:0] grp_fail;

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        cmb_bist_if bif();
        assign bif.start = grp_start_q[g];
        assign grp_busy[g] = bif.busy;
        assign grp_done[g] = bif.done;
        assign grp_fail[WAYS*g +: WAYS] = bif.fail;

        cmb_bist_group #(
            .AW(BIST_AW),
            .DW(BIST_DW)
        ) u_grp (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .ctl(bif.eng),
            .ram_addr(bist_addr[g]),
            .ram_wdata(bist_wdata[g]),
            .ram_we(bist_we[g]),
            .ram_re(bist_re[g]),
            .ram_q0(bist_q_way0[g]),
            .ram_q1(bist_q_way1[g])
        );
    end

    wire bist_launch = wr_tctrl & rbus.wdata[STEST_GO_BIT] & ~running_q;
    wire bist_all_done = running_q & ~|grp_start_q & ~|grp_act_q;

    // Self-test control; a control write during a run is ignored
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            go_q <= 1'b0;
            grp_sel_q <= GRP_SEL_RST;
            finish_q <= 1'b0;
            fail_q <= FAIL_RST;
            running_q <= 1'b0;
            grp_start_q <= '0;
            grp_act_q <= '0;
        end else begin
            grp_start_q <= '0;
            if (wr_tctrl && !running_q) begin
                go_q <= rbus.wdata[STEST_GO_BIT];
                grp_sel_q <= rbus.wdata[STEST_GRP_LSB +: NUM_GROUPS];
            end
            if (bist_launch) begin
                running_q <= 1'b1;
                finish_q <= 1'b0;
                fail_q <= FAIL_RST;
                grp_start_q <= rbus.wdata[STEST_GRP_LSB +: NUM_GROUPS];
                grp_act_q <= rbus.wdata[STEST_GRP_LSB +: NUM_GROUPS];
            end else begin
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    if (grp_done[g]) begin
                        grp_act_q[g] <= 1'b0;
                        fail_q[WAYS*g +: WAYS] <= grp_fail[WAYS*g +: WAYS];
                    end
                end
                if (bist_all_done) begin
                    running_q <= 1'b0;
                    finish_q <= 1'b1;
                end
            end
        end
    end

    // Read mux; unmapped addresses read zero
    wire [31:0] rd_cmd = {{(32 - CMD_W){1'b0}}, cmd_q};
    wire [31:0] rd_tctrl = {16'h0000, go_q, 3'b000, grp_sel_q, 8'h00};
    wire [31:0] rd_tres = {finish_q, 23'h00_0000, fail_q};
    assign rbus.rdata = sel_cmd ? rd_cmd :
                        sel_target ? target_q :
                        sel_tctrl ? rd_tctrl :
                        sel_tres ? rd_tres : 32'h0000_0000;

    // Outputs
    assign mnt_req = req_q;
    assign mnt_op = op_q;
    assign mnt_instr_side = iside_q;
    assign mnt_data_side = dside_q;
    assign mnt_way = way_q;
    assign mnt_line_addr = line_q;
    assign bist_running = running_q;
endmodule // cmb_cache_maint

// File: logic/cmb_if.sv
interface cmb_reg_if;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr, output addr, output wdata, input rdata);
    modport regs (input wr, input addr, input wdata, output rdata);
endinterface

interface cmb_bist_if;
    logic start;
    logic busy;
    logic done;
    logic [1:0] fail;
    modport eng (input start, output busy, output done, output fail);
    modport ctl (output start, input busy, input done, input fail);
endinterface

// File: logic/cmb_pkg.sv
package cmb_pkg;

    // Register byte addresses
    localparam logic [31:0] CMD_ADDR = 32'hfff02004;
    localparam logic [31:0] TARGET_ADDR = 32'hfff02008;
    localparam logic [31:0] STEST_CTRL_ADDR = 32'hfff60000;
    localparam logic [31:0] STEST_RES_ADDR = 32'hfff60004;

    // Reset values
    localparam logic [31:0] TARGET_RST = 32'h0000_0000;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [3:0] GRP_SEL_RST = 4'h0;
    localparam logic [7:0] FAIL_RST = 8'h00;

    // Maintenance command register fields
    localparam int CMD_W = 8;
    localparam int CMD_ISIDE_BIT = 0;
    localparam int CMD_DSIDE_BIT = 1;
    localparam int CMD_FLUSH_ALL_BIT = 2;
    localparam int CMD_FLUSH_LINE_BIT = 3;
    localparam int CMD_UNLOCK_ALL_BIT = 5;
    localparam int CMD_UNLOCK_LINE_BIT = 6;
    localparam int CMD_DRAIN_BIT = 7;
    localparam logic [7:0] CMD_WR_MASK = 8'hef;
    localparam logic [7:0] CMD_OP_MASK = 8'hec;

    // Line target register fields
    localparam int TARGET_WAY_BIT = 31;
    localparam int TARGET_LINE_W = 31;

    // Self-test control and result fields
    localparam int STEST_GO_BIT = 15;
    localparam int STEST_GRP_LSB = 8;
    localparam int NUM_GROUPS = 4;
    localparam int STEST_FINISH_BIT = 31;
    localparam int FAIL_W = 8;
    localparam int WAYS = 2;

    // Bus
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        MNT_IDLE = 2'b01,
        MNT_WAIT = 2'b10
    } cmb_mnt_state_type;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_FLUSH_LINE = 3'h1,
        OP_FLUSH_ALL = 3'h2,
        OP_UNLOCK_LINE = 3'h3,
        OP_UNLOCK_ALL = 3'h4,
        OP_DRAIN = 3'h5
    } cmb_op_type;

    typedef enum logic [5:0] {
        BST_IDLE = 6'b000001,
        BST_WR0 = 6'b000010,
        BST_RD0 = 6'b000100,
        BST_WR1 = 6'b001000,
        BST_RD1 = 6'b010000,
        BST_FIN = 6'b100000
    } cmb_bist_state_type;

endpackage

// File: verification/cmb_cache_maint_properties.sv
module cmb_maint_props import cmb_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Maintenance and self-test
    input wire logic mnt_req,
    input cmb_op_type mnt_op,
    input wire logic mnt_instr_side,
    input wire logic mnt_data_side,
    input wire logic mnt_done,
    input wire logic bist_running
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic wr_ctl_q;
    wire line_op = mnt_op == OP_FLUSH_LINE || mnt_op == OP_UNLOCK_LINE;
    // Remembers a pending self-test control write until its data phase
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn) wr_ctl_q <= 1'b0;
        else if (hready) wr_ctl_q <= hsel && htrans[1] && hwrite && haddr == STEST_CTRL_ADDR;
    property p_okay; hresp == HRESP_OKAY; endproperty
    property p_wait; hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout; endproperty
    property p_hold; mnt_req && !mnt_done |=> mnt_req && $stable(mnt_op); endproperty
    property p_clear; mnt_req && mnt_done |=> !mnt_req && mnt_op == OP_NONE; endproperty
    property p_line; mnt_req && line_op |-> !(mnt_instr_side && mnt_data_side); endproperty
    property p_drain; mnt_req && mnt_op == OP_DRAIN |-> mnt_data_side && !mnt_instr_side; endproperty
    property p_side; mnt_req |-> mnt_instr_side || mnt_data_side; endproperty
    property p_idle; !mnt_req |-> mnt_op == OP_NONE; endproperty
    property p_go; wr_ctl_q && !hready && hwdata[STEST_GO_BIT] && !bist_running |=> bist_running; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    a_wait: assert property (p_wait) else $error("wait state not one cycle");
    a_hold: assert property (p_hold) else $error("request dropped before done");
    a_clear: assert property (p_clear) else $error("request kept after done");
    a_line: assert property (p_line) else $error("line op issued to both caches");
    a_drain: assert property (p_drain) else $error("drain issued with wrong select");
    a_side: assert property (p_side) else $error("request with no cache selected");
    a_idle: assert property (p_idle) else $error("op code shown while idle");
    a_go: assert property (p_go) else $error("self-test did not start");
    c_done: cover property (mnt_req && mnt_done);
    c_drain: cover property (mnt_req && mnt_op == OP_DRAIN);
    c_both: cover property (mnt_req && mnt_instr_side && mnt_data_side);
    c_bist: cover property ($fell(bist_running));
endmodule // cmb_maint_props

bind cmb_cache_maint cmb_maint_props u_props (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .mnt_req(mnt_req), .mnt_op(mnt_op), .mnt_instr_side(mnt_instr_side), .mnt_data_side(mnt_data_side),
    .mnt_done(mnt_done), .bist_running(bist_running));

// File: verification/cmb_cache_maint_tb_top.sv
module cmb_cache_maint_tb_top import cmb_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rstn, hsel, hwrite, hreadyout, hresp, mnt_done, stall;
    logic mnt_req, mnt_instr_side, mnt_data_side, mnt_way, bist_running;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rnd, rd;
    cmb_op_type mnt_op;
    logic [30:0] mnt_line_addr;
    logic [3:0][2:0] bist_addr;
    logic [3:0][7:0] bist_wdata, bist_q_way0, bist_q_way1;
    logic [3:0] bist_we, bist_re, sel;
    logic [7:0] fm, f, cv;
    logic [7:0] mem [2][4][8];
    logic [36:0] exp_q[$], obs_q[$];
    int miscompares, total_checks;
    int opb[5] = '{2, 3, 5, 6, 7};
    cmb_op_type opv[5] = '{OP_FLUSH_ALL, OP_FLUSH_LINE, OP_UNLOCK_ALL, OP_UNLOCK_LINE, OP_DRAIN};
    logic [3:0] bsel[5] = '{4'hf, 4'hf, 4'h5, 4'ha, 4'h0};
    logic [7:0] bfm[5] = '{8'h00, 8'h96, 8'hff, 8'h69, 8'hff};

    cmb_cache_maint #(.BIST_AW(3), .BIST_DW(8)) uut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mnt_req(mnt_req), .mnt_op(mnt_op),
        .mnt_instr_side(mnt_instr_side), .mnt_data_side(mnt_data_side), .mnt_way(mnt_way),
        .mnt_line_addr(mnt_line_addr), .mnt_done(mnt_done), .bist_addr(bist_addr), .bist_wdata(bist_wdata),
        .bist_we(bist_we), .bist_re(bist_re), .bist_q_way0(bist_q_way0), .bist_q_way1(bist_q_way1),
        .bist_running(bist_running));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Test RAMs per group and way; a set bit in fm flips bit 0 of that way's read data
    always @(posedge sys_clk) begin
        for (int g = 0; g < 4; g++) begin
            if (bist_we[g]) begin
                mem[0][g][bist_addr[g]] <= bist_wdata[g];
                mem[1][g][bist_addr[g]] <= bist_wdata[g];
            end
            bist_q_way0[g] <= mem[0][g][bist_addr[g]] ^ {7'h0, fm[2 * g]};
            bist_q_way1[g] <= mem[1][g][bist_addr[g]] ^ {7'h0, fm[2 * g + 1]};
        end
    end

    // Cache controller stand-in: logs each request and answers after a random delay
    initial begin
        mnt_done = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (mnt_req === 1'b1) begin
                obs_q.push_back({mnt_op, mnt_instr_side, mnt_data_side, mnt_way, mnt_line_addr});
                repeat (rnd[1:0]) @(posedge sys_clk);
                while (stall) @(posedge sys_clk);
                mnt_done <= 1'b1;
                @(posedge sys_clk);
                mnt_done <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Expected requests: one per valid command bit, lowest bit first: 2, 3, 5, 6, 7
    task automatic model_cmd(input logic [7:0] c, input logic [31:0] t);
        logic ok;
        for (int k = 0; k < 5; k++) begin
            ok = (k == 1 || k == 3) ? c[0] ^ c[1] : (k == 4 ? c[1] & !c[0] : c[0] | c[1]);
            if (c[opb[k]] && ok) exp_q.push_back({opv[k], c[0], c[1], t});
        end
    endtask

    task automatic finish_cmd(input logic [7:0] c);
        for (int n = 0; n < 40; n++) begin
            ahb(1'b0, CMD_ADDR, 32'h0);
            if ((rd & 32'hec) == 32'h0) break;
        end
        chk(rd, {30'h0, c[1:0]});
        chk(obs_q.size(), exp_q.size());
        while (exp_q.size() > 0 && obs_q.size() > 0) chk(obs_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
        obs_q.delete();
        rnd = lfsr(rnd);
    endtask

    task automatic run_cmd(input logic [7:0] c);
        logic [31:0] t;
        t = rnd;
        ahb(1'b1, TARGET_ADDR, t);
        rdc(TARGET_ADDR, t);
        model_cmd(c, t);
        ahb(1'b1, CMD_ADDR, {24'h0, c});
        finish_cmd(c);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        end_sim();
    end

    initial begin
        {hsel, hwrite, stall, rstn} = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        {haddr, hwdata, rd, fm} = '0;
        rnd = 32'h555f896a;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        hsel <= 1'b1;
        @(posedge sys_clk);
        rdc(CMD_ADDR, 32'h0);
        rdc(TARGET_ADDR, TARGET_RST);
        rdc(STEST_CTRL_ADDR, 32'h0);
        rdc(STEST_RES_ADDR, 32'h0);
        ahb(1'b1, STEST_RES_ADDR, 32'hffffffff);
        rdc(STEST_RES_ADDR, 32'h0);
        ahb(1'b1, 32'hfff0200c, 32'h12345678);
        rdc(32'hfff0200c, 32'h0);
        $display("test register map done");
        for (int k = 0; k < 28; k++) begin
            cv = (k < 20) ? 8'(1 << opb[k / 4]) | 8'(k % 4) : rnd[7:0] & 8'hef;
            run_cmd(cv);
        end
        $display("test command decode done");
        stall <= 1'b1;
        ahb(1'b1, TARGET_ADDR, 32'h80000040);
        model_cmd(8'h06, 32'h80000040);
        ahb(1'b1, CMD_ADDR, 32'h06);
        repeat (4) @(posedge sys_clk);
        rdc(CMD_ADDR, 32'h06);
        ahb(1'b1, CMD_ADDR, 32'h09);
        rdc(CMD_ADDR, 32'h06);
        stall <= 1'b0;
        finish_cmd(8'h06);
        $display("test busy command done");
        for (int k = 0; k < 5; k++) begin
            sel = bsel[k];
            f = (k == 1) ? rnd[7:0] : bfm[k];
            fm <= f;
            ahb(1'b1, STEST_CTRL_ADDR, {16'h0, 1'b1, 3'h0, sel, 8'h0});
            rdc(STEST_CTRL_ADDR, {16'h0, 1'b1, 3'h0, sel, 8'h0});
            if (k < 4) rdc(STEST_RES_ADDR, 32'h0);
            for (int n = 0; n < 100; n++) begin
                ahb(1'b0, STEST_RES_ADDR, 32'h0);
                if (rd[31] === 1'b1) break;
            end
            chk(rd, {1'b1, 23'h0, f & {{2{sel[3]}}, {2{sel[2]}}, {2{sel[1]}}, {2{sel[0]}}}});
        end
        $display("test self-test done");
        end_sim();
    end
endmodule // cmb_cache_maint_tb_top
